/* File: src/asc_consts.svh */
// Purpose: Constants of the ADC scan controller.
// Assumes: Included by bare name; byte addresses on the register bus.
// Notes:   Definitions only.
// Operation
// - The controller drives a 3-bit select code to the 8:1 analog mux.
// - Software sets the resolution to any width from 2 to 10 bits.
// - A 10-bit conversion takes exactly 11 clocks from sample to result.
// - The first cycle samples the input; each later cycle resolves a bit.
// - A conversion at resolution N occupies N plus 1 clocks.
// - Each channel owns a pair of 10-bit result registers.
// - Each channel is included or excluded by its own enable bit.
// - A scan begins on a software start command.
// - Continuous mode starts a new scan as soon as the last one ends.
// - Single mode does one scan and waits for another start command.
// - One scan interrupt marks a finished scan with valid results.
`ifndef ASC_CONSTS_SVH
`define ASC_CONSTS_SVH

`define ASC_AW            7
`define ASC_DW            32
`define ASC_RW            10
`define ASC_NCH           8
`define ASC_MEM_DEPTH     16

`define ASC_OFF_CTRL      7'h00
`define ASC_OFF_CHEN      7'h04
`define ASC_OFF_START     7'h08
`define ASC_OFF_STATUS    7'h0c
`define ASC_OFF_IRQ_STAT  7'h10
`define ASC_OFF_IRQ_CLR   7'h14
`define ASC_OFF_IRQ_EN    7'h18
`define ASC_RES_AREA_BIT  6

`define ASC_CTRL_CONT     0
`define ASC_CTRL_PD       1
`define ASC_CTRL_RES_LSB  8
`define ASC_CTRL_RES_MSB  11
`define ASC_START_BIT     0
`define ASC_STAT_BUSY     0
`define ASC_STAT_SEL_LSB  4
`define ASC_STAT_SEL_MSB  6
`define ASC_STAT_BANK     8
`define ASC_IRQ_SCAN      0

`define ASC_RES_RST       4'ha
`define ASC_RES_MIN       4'h2
`define ASC_RES_MAX       4'ha
`define ASC_CHEN_RST      8'hff
`define ASC_MSB_TRIAL     10'h200
`define ASC_FIRST_BIT     4'h1

`endif

/* File: src/asc_pkg.sv */
// Purpose: Types of the ADC scan controller.
// Assumes: asc_consts.svh gives the widths.
// Notes:   State enum is one-hot.
`default_nettype none
`include "asc_consts.svh"

package asc_pkg;

  typedef enum logic [2:0] {
    ASC_IDLE   = 3'b001,
    ASC_SAMPLE = 3'b010,
    ASC_CONV   = 3'b100
  } asc_state_e;

  typedef struct packed {
    logic [`ASC_MEM_DEPTH-1:0][`ASC_RW-1:0] word;
    logic [`ASC_RW-1:0]                     rdata;
  } asc_mem_s;

  typedef struct packed {
    asc_state_e          st;
    logic [2:0]          sel;
    logic                sample;
    logic [`ASC_RW-1:0]  dac;
    logic [`ASC_RW-1:0]  bitm;
    logic [3:0]          cnt;
    logic [3:0]          res;
    logic                bank;
    logic                last_bank;
    logic                pd;
    logic                cont;
    logic                pd_cfg;
    logic [3:0]          res_cfg;
    logic [`ASC_NCH-1:0] chen;
    logic                irq_st;
    logic                irq_en;
    logic                irq;
    logic                pend;
    logic                waitreq;
    logic [`ASC_DW-1:0]  rdata;
  } asc_top_s;

endpackage : asc_pkg

`default_nettype wire

/* File: src/asc_result_mem.sv */
// Purpose: Result store, two 10-bit words per channel.
// Assumes: One write and one read port on the same clock.
// Notes:   Read data registered; a read the cycle after a write sees it.
`default_nettype none
`include "asc_consts.svh"

module asc_result_mem
  import asc_pkg::*;
(
  input  wire logic                     clk_i,
  input  wire logic                     nrst_i,
  input  wire logic                     we_i,
  input  wire logic [3:0]               waddr_i,
  input  wire logic [`ASC_RW-1:0]       wdata_i,
  input  wire logic [3:0]               raddr_i,
  output logic      [`ASC_RW-1:0]       rdata_o
);

  asc_mem_s mem_ff;
  asc_mem_s nxt_mem;

  always_comb begin
    nxt_mem       = mem_ff;
    nxt_mem.rdata = mem_ff.word[raddr_i];
    if (we_i) begin
      nxt_mem.word[waddr_i] = wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mem_ff <= '0;
    end else begin
      mem_ff <= nxt_mem;
    end
  end

  assign rdata_o = mem_ff.rdata;

endmodule : asc_result_mem

`default_nettype wire

/* File: src/asc_scan_ctrl.sv */
// Purpose: Scan sequencer and SAR control for an 8-input 10-bit ADC.
// Assumes: clk_i is the conversion clock; cmp_i answers dac_code_o within the same clk_i cycle.
// Notes:   Avalon-MM slave with waitrequest, one level interrupt.
`default_nettype none
`include "asc_consts.svh"

module asc_scan_ctrl
  import asc_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                nrst_i,
  input  wire logic [`ASC_AW-1:0]  avs_address_i,
  input  wire logic                avs_read_i,
  input  wire logic                avs_write_i,
  input  wire logic [`ASC_DW-1:0]  avs_writedata_i,
  output logic      [`ASC_DW-1:0]  avs_readdata_o,
  output logic                     avs_waitrequest_o,
  output logic                     irq_o,
  output logic      [2:0]          mux_sel_o,
  output logic                     sample_o,
  output logic      [`ASC_RW-1:0]  dac_code_o,
  output logic                     adc_pd_o,
  input  wire logic                cmp_i
);

  asc_top_s           s_ff;
  asc_top_s           nxt_s;
  logic               mem_we;
  logic [3:0]         mem_waddr;
  logic [`ASC_RW-1:0] mem_wdata;
  logic [`ASC_RW-1:0] mem_rdata;

  // First included channel at or above 'from'; msb says one was found
  function automatic logic [3:0] asc_find(input logic [`ASC_NCH-1:0] mask,
                                          input logic [3:0]          from);
    logic [3:0] r;
    r = 4'h0;
    for (int i = `ASC_NCH - 1; i >= 0; i--) begin
      if (mask[i] && (4'(i) >= from)) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction : asc_find

  // Out-of-range settings are pulled into the legal window
  function automatic logic [3:0] asc_clamp(input logic [3:0] r);
    logic [3:0] c;
    c = r;
    if (r < `ASC_RES_MIN) begin
      c = `ASC_RES_MIN;
    end else if (r > `ASC_RES_MAX) begin
      c = `ASC_RES_MAX;
    end
    return c;
  endfunction : asc_clamp

  function automatic logic [`ASC_DW-1:0] asc_reg_read(
    input asc_top_s           s,
    input logic [`ASC_AW-1:0] a,
    input logic [`ASC_RW-1:0] md
  );
    logic [`ASC_DW-1:0] d;
    d = '0;
    if (a[`ASC_RES_AREA_BIT]) begin
      d[`ASC_RW-1:0] = md;
    end else begin
      case (a)
        `ASC_OFF_CTRL: begin
          d[`ASC_CTRL_CONT] = s.cont;
          d[`ASC_CTRL_PD]   = s.pd_cfg;
          d[`ASC_CTRL_RES_MSB:`ASC_CTRL_RES_LSB] = s.res_cfg;
        end
        `ASC_OFF_CHEN: begin
          d[`ASC_NCH-1:0] = s.chen;
        end
        `ASC_OFF_STATUS: begin
          d[`ASC_STAT_BUSY] = (s.st != ASC_IDLE);
          d[`ASC_STAT_SEL_MSB:`ASC_STAT_SEL_LSB] = s.sel;
          d[`ASC_STAT_BANK] = s.last_bank;
        end
        `ASC_OFF_IRQ_STAT: begin
          d[`ASC_IRQ_SCAN] = s.irq_st;
        end
        `ASC_OFF_IRQ_EN: begin
          d[`ASC_IRQ_SCAN] = s.irq_en;
        end
        default: begin
          d = '0;
        end
      endcase
    end
    return d;
  endfunction : asc_reg_read

  asc_result_mem u_mem (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .we_i    (mem_we),
    .waddr_i (mem_waddr),
    .wdata_i (mem_wdata),
    .raddr_i (avs_address_i[5:2]),
    .rdata_o (mem_rdata)
  );

  always_comb begin
    logic [3:0]         hit;
    logic [`ASC_RW-1:0] keep;
    logic               wr_take;
    logic               start_cmd;
    logic               clr_cmd;
    logic               scan_end;
    hit       = 4'h0;
    keep      = '0;
    scan_end  = 1'b0;
    nxt_s     = s_ff;
    mem_we    = 1'b0;
    mem_waddr = {s_ff.sel, s_ff.bank};
    mem_wdata = '0;

    // Bus: request taken, one wait cycle, then one cycle of waitrequest low
    wr_take   = avs_write_i && !s_ff.waitreq;
    start_cmd = wr_take && (avs_address_i == `ASC_OFF_START) &&
                avs_writedata_i[`ASC_START_BIT];
    clr_cmd   = wr_take && (avs_address_i == `ASC_OFF_IRQ_CLR) &&
                avs_writedata_i[`ASC_IRQ_SCAN];
    nxt_s.waitreq = 1'b1;
    if ((avs_read_i || avs_write_i) && s_ff.waitreq && !s_ff.pend) begin
      nxt_s.pend = 1'b1;
    end
    if (s_ff.pend) begin
      nxt_s.pend    = 1'b0;
      nxt_s.waitreq = 1'b0;
      if (avs_read_i) begin
        nxt_s.rdata = asc_reg_read(s_ff, avs_address_i, mem_rdata);
      end
    end
    if (wr_take) begin
      case (avs_address_i)
        `ASC_OFF_CTRL: begin
          nxt_s.cont    = avs_writedata_i[`ASC_CTRL_CONT];
          nxt_s.pd_cfg  = avs_writedata_i[`ASC_CTRL_PD];
          nxt_s.res_cfg = avs_writedata_i[`ASC_CTRL_RES_MSB:
                                          `ASC_CTRL_RES_LSB];
        end
        `ASC_OFF_CHEN: begin
          nxt_s.chen = avs_writedata_i[`ASC_NCH-1:0];
        end
        `ASC_OFF_IRQ_EN: begin
          nxt_s.irq_en = avs_writedata_i[`ASC_IRQ_SCAN];
        end
        default: begin
          nxt_s.chen = s_ff.chen;
        end
      endcase
    end

    nxt_s.sample = 1'b0;
    case (s_ff.st)
      ASC_IDLE: begin
        hit = asc_find(s_ff.chen, 4'h0);
        // Start with no channel included is ignored
        if (start_cmd && hit[3]) begin
          nxt_s.st     = ASC_SAMPLE;
          nxt_s.sel    = hit[2:0];
          nxt_s.sample = 1'b1;
          nxt_s.res    = asc_clamp(s_ff.res_cfg);
          nxt_s.dac    = '0;
        end
      end
      ASC_SAMPLE: begin
        // Sample cycle done; trial of the top bit next
        nxt_s.st   = ASC_CONV;
        nxt_s.dac  = `ASC_MSB_TRIAL;
        nxt_s.bitm = `ASC_MSB_TRIAL;
        nxt_s.cnt  = `ASC_FIRST_BIT;
      end
      ASC_CONV: begin
        keep = cmp_i ? s_ff.dac : (s_ff.dac & ~s_ff.bitm);
        if (s_ff.cnt == s_ff.res) begin
          mem_we    = 1'b1;
          mem_wdata = keep;
          nxt_s.dac = keep;
          // Mask changes made mid-scan apply to channels not yet reached
          hit = asc_find(s_ff.chen, {1'b0, s_ff.sel} + 4'h1);
          if (hit[3]) begin
            nxt_s.st     = ASC_SAMPLE;
            nxt_s.sel    = hit[2:0];
            nxt_s.sample = 1'b1;
            nxt_s.dac    = '0;
          end else begin
            scan_end = 1'b1;
          end
        end else begin
          nxt_s.dac  = keep | (s_ff.bitm >> 1);
          nxt_s.bitm = s_ff.bitm >> 1;
          nxt_s.cnt  = s_ff.cnt + 4'h1;
        end
      end
      default: begin
        nxt_s.st = ASC_IDLE;
      end
    endcase

    if (scan_end) begin
      // Banks alternate so software reads a whole scan while the next runs
      nxt_s.last_bank = s_ff.bank;
      nxt_s.bank      = ~s_ff.bank;
      hit = asc_find(s_ff.chen, 4'h0);
      if (s_ff.cont && hit[3]) begin
        nxt_s.st     = ASC_SAMPLE;
        nxt_s.sel    = hit[2:0];
        nxt_s.sample = 1'b1;
        nxt_s.res    = asc_clamp(s_ff.res_cfg);
        nxt_s.dac    = '0;
      end else begin
        nxt_s.st = ASC_IDLE;
      end
    end

    // Set wins over a clear in the same cycle
    if (clr_cmd) begin
      nxt_s.irq_st = 1'b0;
    end
    if (scan_end) begin
      nxt_s.irq_st = 1'b1;
    end
    nxt_s.irq = nxt_s.irq_st && nxt_s.irq_en;
    nxt_s.pd  = nxt_s.pd_cfg && (nxt_s.st == ASC_IDLE);
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_ff         <= '0;
      s_ff.st      <= ASC_IDLE;
      s_ff.res     <= `ASC_RES_RST;
      s_ff.res_cfg <= `ASC_RES_RST;
      s_ff.chen    <= `ASC_CHEN_RST;
      s_ff.waitreq <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign avs_readdata_o    = s_ff.rdata;
  assign avs_waitrequest_o = s_ff.waitreq;
  assign irq_o             = s_ff.irq;
  assign mux_sel_o         = s_ff.sel;
  assign sample_o          = s_ff.sample;
  assign dac_code_o        = s_ff.dac;
  assign adc_pd_o          = s_ff.pd;

endmodule : asc_scan_ctrl

`default_nettype wire

/* File: verif/asc_scan_ctrl_properties.sv */
// Purpose: Port checks of the scan controller.
// Assumes: Sees only top-level ports.
// Notes:   Bound at the foot of this file.
`default_nettype none
`include "asc_consts.svh"
module asc_scan_ctrl_properties (
  input wire logic               clk_i,
  input wire logic               nrst_i,
  input wire logic               avs_read_i,
  input wire logic               avs_write_i,
  input wire logic [`ASC_DW-1:0] avs_readdata_o,
  input wire logic               avs_waitrequest_o,
  input wire logic [2:0]         mux_sel_o,
  input wire logic               sample_o,
  input wire logic [`ASC_RW-1:0] dac_code_o,
  input wire logic               adc_pd_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  bus_answer_a: assert property ($rose(avs_read_i || avs_write_i) |->
    avs_waitrequest_o ##1 avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("bus answer late or early");
  upper_zero_a: assert property (avs_read_i && !avs_waitrequest_o |->
    avs_readdata_o[31:12] == 20'h0) else $error("upper read bits set");
  sel_hold_a: assert property (
    sample_o |=> $stable(mux_sel_o) [*2]) else $error("select moved");
  sel_change_a: assert property (
    $changed(mux_sel_o) |-> sample_o) else $error("select off start");
  sample_gap_a: assert property (
    sample_o |=> !sample_o [*2]) else $error("conversion too short");
  msb_trial_a: assert property (
    sample_o |=> dac_code_o == `ASC_MSB_TRIAL) else $error("bad first trial");
  pd_idle_a: assert property (
    adc_pd_o |-> !sample_o) else $error("sampling while powered down");
endmodule : asc_scan_ctrl_properties
bind asc_scan_ctrl asc_scan_ctrl_properties asc_scan_ctrl_properties_i (
  .clk_i(clk_i), .nrst_i(nrst_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .mux_sel_o(mux_sel_o),
  .sample_o(sample_o), .dac_code_o(dac_code_o), .adc_pd_o(adc_pd_o));
`default_nettype wire

/* File: verif/asc_adc_model.sv */
// Purpose: Mux, sample-hold and comparator of the converter.
// Assumes: Comparator answers in the trial cycle.
// Notes:   Powered down it gives a pattern, not a level.
`default_nettype none
`include "asc_consts.svh"
module asc_adc_model (
  input  wire logic                        clk_i,
  input  wire logic                        sample_i,
  input  wire logic [2:0]                  sel_i,
  input  wire logic [`ASC_RW-1:0]          dac_i,
  input  wire logic                        pd_i,
  input  wire logic [`ASC_NCH*`ASC_RW-1:0] lvl_i,
  output logic                             cmp_o
);
  logic [`ASC_RW-1:0] held;
  always_ff @(posedge clk_i)
    if (sample_i) held <= lvl_i[sel_i*`ASC_RW +: `ASC_RW];
  assign cmp_o = pd_i ? ^dac_i : (held >= dac_i);
endmodule : asc_adc_model
`default_nettype wire

/* File: verif/asc_scan_ctrl_tb_top.sv */
// Purpose: Self-checking bench of the scan controller.
// Assumes: Bus answer fixed by the design, waited for anyway.
// Notes:   Banks alternate per completed scan.
`default_nettype none
`include "asc_consts.svh"
module asc_scan_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, nrst_i, rd, wr, wq, irq, smp, pd, cmp;
  logic [6:0]  addr;
  logic [31:0] wdat, rdat, got;
  logic [2:0]  sel;
  logic [9:0]  dac;
  logic [79:0] lvl;
  int          num_errors, num_checks, cyc, bank;
  int          st_q[$];
  logic [2:0]  sel_q[$];
  asc_scan_ctrl asc_scan_ctrl_i (.clk_i(clk_i), .nrst_i(nrst_i),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wq), .irq_o(irq), .mux_sel_o(sel),
    .sample_o(smp), .dac_code_o(dac), .adc_pd_o(pd), .cmp_i(cmp));
  asc_adc_model asc_adc_model_i (.clk_i(clk_i), .sample_i(smp),
    .sel_i(sel), .dac_i(dac), .pd_i(pd), .lvl_i(lvl), .cmp_o(cmp));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (smp === 1'b1) begin
      st_q.push_back(cyc);
      sel_q.push_back(sel);
    end
  end
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  // Idle edge first, so every request is a fresh rise
  task automatic bus(input logic w, input logic [6:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk_i);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdat <= d;
    n = 0;
    // No cycle limit here; only the watchdog may end a hung access
    do begin
      @(posedge clk_i);
      n++;
    end while (wq !== 1'b0);
    chk(32'd3, n);
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic rdchk(input logic [6:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(e, got);
  endtask : rdchk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  task automatic t_regs;
    rdchk(`ASC_OFF_CTRL, 32'h00000a00);
    rdchk(`ASC_OFF_CHEN, 32'h000000ff);
    bus(1'b1, 7'h20, 32'hffffffff);
    rdchk(7'h20, 32'h0);
    rdchk(7'h40, 32'h0);
    $display("test regs done");
  endtask : t_regs
  task automatic t_single(input int r, input logic [7:0] en);
    int n0, k;
    bus(1'b1, `ASC_OFF_CTRL, 32'(r) << 8);
    bus(1'b1, `ASC_OFF_CHEN, {24'h0, en});
    bus(1'b1, `ASC_OFF_IRQ_EN, 32'h1);
    n0 = st_q.size();
    bus(1'b1, `ASC_OFF_START, 32'h1);
    k = 0;
    while (irq !== 1'b1 && k < 500) begin
      @(posedge clk_i);
      k++;
    end
    chk(1'b1, irq);
    k = n0;
    for (int ch = 0; ch < 8; ch++) begin
      if (en[ch]) begin
        chk(ch, sel_q[k]);
        if (k > n0) chk(r + 1, st_q[k] - st_q[k-1]);
        rdchk(7'h40 + 7'(8 * ch + 4 * bank),
              lvl[ch*10 +: 10] & (10'h3ff << (10 - r)));
        k++;
      end
    end
    chk(k, st_q.size());
    bus(1'b0, `ASC_OFF_STATUS, 32'h0);
    chk(bank << 8, got & 32'h101);
    bus(1'b1, `ASC_OFF_IRQ_CLR, 32'h1);
    tick(2);
    chk(1'b0, irq);
    tick(30);
    chk(k, st_q.size());
    bank ^= 1;
    $display("test single res %0d done", r);
  endtask : t_single
  task automatic t_cont;
    int n0;
    bus(1'b1, `ASC_OFF_CTRL, 32'h301);
    bus(1'b1, `ASC_OFF_CHEN, 32'h11);
    n0 = st_q.size();
    bus(1'b1, `ASC_OFF_START, 32'h1);
    tick(30);
    chk(4, st_q[n0+2] - st_q[n0+1]);
    chk(3'h0, sel_q[n0+2]);
    bus(1'b1, `ASC_OFF_IRQ_EN, 32'h0);
    tick(2);
    chk(1'b0, irq);
    bus(1'b1, `ASC_OFF_CTRL, 32'h302);
    tick(20);
    bus(1'b1, `ASC_OFF_IRQ_EN, 32'h1);
    tick(2);
    chk(1'b1, irq);
    chk(1'b1, pd);
    bus(1'b1, `ASC_OFF_CHEN, 32'h0);
    bus(1'b1, `ASC_OFF_IRQ_CLR, 32'h1);
    n0 = st_q.size();
    bus(1'b1, `ASC_OFF_START, 32'h1);
    tick(20);
    chk(n0, st_q.size());
    chk(1'b0, irq);
    $display("test continuous done");
  endtask : t_cont
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  initial begin
    {nrst_i, rd, wr, addr, wdat} = '0;
    lvl = {10'h3ff, 10'h000, 10'h2c7, 10'h1a5,
           10'h355, 10'h0aa, 10'h201, 10'h1ff};
    tick(8);
    nrst_i <= 1'b1;
    t_regs();
    t_single(10, 8'h96);
    t_single(2, 8'h41);
    t_single(5, 8'h2c);
    t_cont();
    close_out();
  end
  initial begin
    #160000;
    num_errors++;
    close_out();
  end
endmodule : asc_scan_ctrl_tb_top
`default_nettype wire
